// >>> core/eee_pcs_status_regs.sv
// EEE status, capability, counter and advertisement register bank.
// Assumes PCS status inputs come from logic on sys_clk_i; strap is a pin.
`default_nettype none
`include "eee_regs_defines.svh"

// Notes on behaviour
// - TX LPI seen bit latches high
// - RX LPI seen bit latches high
// - TX LPI now bit is live
// - RX LPI now bit is live
// - TX clock stoppable reads one
// - Capability: 100 supported, 1000 not
// - Wake faults increment the counter
// - Reading the counter clears it
// - Counter saturates at all ones
// - PCS soft reset clears counter
// - Writable advertise bit, strap-loaded default one
// - Partner ability bit, resets zero
// - Self-clearing PCS reset clears EEE spaces
// - Vendor enable off ignores EEE registers
module eee_pcs_status_regs
    import eee_regs_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        tx_lpi_now_i,
    input  wire logic        rx_lpi_now_i,
    input  wire logic        wake_fault_i,
    input  wire logic        partner_adv_valid_i,
    input  wire logic        partner_adv_100_i,
    input  wire logic        adv_strap_i,
    output logic             eee_negotiate_100_o
);
    reg_req_type    req;
    pcs_events_type ev;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign ev  = '{tx_lpi_now: tx_lpi_now_i, rx_lpi_now: rx_lpi_now_i,
                   wake_fault: wake_fault_i,
                   partner_adv_valid: partner_adv_valid_i,
                   partner_adv_100: partner_adv_100_i};

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] off);
        hit = (a == off);
    endfunction

    function automatic logic wr_hit(input reg_req_type r,
                                    input logic [15:0] off);
        wr_hit = r.wr && hit(r.addr, off);
    endfunction

    // Strap passes two flops before use; it is loaded once, never tracked
    logic       strap_meta_reg;
    logic       strap_meta_next;
    logic       strap_sync_reg;
    logic       strap_sync_next;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic       strap_loaded_reg;
    logic       strap_loaded_next;
    logic       strap_take;

    logic        tx_seen_reg;
    logic        tx_seen_next;
    logic        rx_seen_reg;
    logic        rx_seen_next;
    logic        adv_reg;
    logic        adv_next;
    logic        partner_reg;
    logic        partner_next;
    logic        enable_reg;
    logic        enable_next;
    logic        soft_reset;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [15:0] wake_count;
    logic        wake_read;

    // PCS reset bit self-clears: the write pulse itself is the reset
    assign soft_reset = wr_hit(req, `ADDR_PCS_CONTROL)
                        && req.wdata[`BIT_PCS_RESET];
    // Load only once the synchroniser holds the pin's own value
    assign strap_take = settle_reg[1] && !strap_loaded_reg;
    assign wake_read  = req.rd && hit(req.addr, `ADDR_WAKE_FAULT_CNT);

    wake_fault_counter_unit counter_inst (
        .sys_clk_i    (sys_clk_i),
        .resetn_i     (resetn_i),
        .fault_i      (ev.wake_fault),
        .read_clear_i (wake_read),
        .soft_reset_i (soft_reset),
        .count_o      (wake_count)
    );

    always_comb begin
        tx_seen_next = tx_seen_reg | ev.tx_lpi_now;
        rx_seen_next = rx_seen_reg | ev.rx_lpi_now;
        adv_next     = adv_reg;
        partner_next = partner_reg;
        enable_next  = enable_reg;
        if (strap_take) begin
            adv_next = strap_sync_reg;
        end
        if (ev.partner_adv_valid) begin
            partner_next = ev.partner_adv_100;
        end
        if (wr_hit(req, `ADDR_EEE_LOCAL_ADV)) begin
            adv_next = req.wdata[`BIT_ADV_100];
        end
        if (wr_hit(req, `ADDR_EEE_VENDOR_CFG)) begin
            enable_next = req.wdata[`BIT_EEE_ENABLE];
        end
        if (soft_reset) begin
            // Vendor enable is outside the cleared spaces; an event in
            // the reset cycle still lands, so none is lost
            tx_seen_next = ev.tx_lpi_now;
            rx_seen_next = ev.rx_lpi_now;
            adv_next     = `RST_ADV_100;
            partner_next = ev.partner_adv_valid & ev.partner_adv_100;
        end
    end

    always_comb begin
        rdata_next = 16'h0000;
        if (req.rd) begin
            unique case (req.addr)
                `ADDR_PCS_LPI_STATUS: begin
                    rdata_next[`BIT_TX_LPI_SEEN] = tx_seen_reg;
                    rdata_next[`BIT_RX_LPI_SEEN] = rx_seen_reg;
                    rdata_next[`BIT_TX_LPI_NOW]  = ev.tx_lpi_now;
                    rdata_next[`BIT_RX_LPI_NOW]  = ev.rx_lpi_now;
                    rdata_next[`BIT_TX_CLK_STOPPABLE] =
                        `RST_TX_CLK_STOPPABLE;
                end
                `ADDR_EEE_SPEED_CAP: begin
                    rdata_next[`BIT_CAP_100]  = `RST_CAP_100;
                    rdata_next[`BIT_CAP_1000] = `RST_CAP_1000;
                end
                `ADDR_WAKE_FAULT_CNT: rdata_next = wake_count;
                `ADDR_EEE_LOCAL_ADV: rdata_next[`BIT_ADV_100] = adv_reg;
                `ADDR_EEE_PARTNER_ABIL:
                    rdata_next[`BIT_PARTNER_100] = partner_reg;
                `ADDR_EEE_VENDOR_CFG:
                    rdata_next[`BIT_EEE_ENABLE] = enable_reg;
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    // Strap group: taken on the third edge after release
    always_comb begin
        strap_meta_next   = adv_strap_i;
        strap_sync_next   = strap_meta_reg;
        settle_next       = {settle_reg[0], 1'b1};
        strap_loaded_next = strap_loaded_reg | settle_reg[1];
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strap_meta_reg   <= 1'b0;
            strap_sync_reg   <= 1'b0;
            settle_reg       <= 2'b00;
            strap_loaded_reg <= 1'b0;
        end else begin
            strap_meta_reg   <= strap_meta_next;
            strap_sync_reg   <= strap_sync_next;
            settle_reg       <= settle_next;
            strap_loaded_reg <= strap_loaded_next;
        end
    end

    // Status group: seen bits, advertise, partner and vendor enable
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_seen_reg      <= 1'b0;
            rx_seen_reg      <= 1'b0;
            adv_reg          <= `RST_ADV_100;
            partner_reg      <= 1'b0;
            enable_reg       <= `RST_EEE_ENABLE;
        end else begin
            tx_seen_reg      <= tx_seen_next;
            rx_seen_reg      <= rx_seen_next;
            adv_reg          <= adv_next;
            partner_reg      <= partner_next;
            enable_reg       <= enable_next;
        end
    end

    // Read data stand one cycle only, so idle cycles read zero
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
    // Disabled EEE ignores capability, advertisement and partner
    assign eee_negotiate_100_o = enable_reg && adv_reg && partner_reg
                                 && `RST_CAP_100;

    a_tx_seen_sticky: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        ((tx_seen_reg || tx_lpi_now_i) && !soft_reset) |=> tx_seen_reg)
        else $error("TX LPI seen not latched");
    a_rx_seen_set: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (rx_lpi_now_i && !soft_reset) |=> rx_seen_reg)
        else $error("RX LPI seen not latched");
    a_rx_seen_hold: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (rx_seen_reg && !soft_reset) |=> rx_seen_reg)
        else $error("RX LPI seen dropped");
    a_live_bits: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == `ADDR_PCS_LPI_STATUS)
        |=> rdata_o[`BIT_TX_LPI_NOW] == $past(tx_lpi_now_i)
            && rdata_o[`BIT_RX_LPI_NOW] == $past(rx_lpi_now_i)
            && rdata_o[`BIT_TX_CLK_STOPPABLE])
        else $error("Live LPI bits wrong");
    a_cap_fixed: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == `ADDR_EEE_SPEED_CAP) |=> rdata_o == 16'h0002)
        else $error("Capability value wrong");
    a_read_clears: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (wake_read && !wake_fault_i && !soft_reset)
        |=> wake_count == 16'h0000)
        else $error("Counter not cleared by read");
    a_adv_write: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == `ADDR_EEE_LOCAL_ADV && !soft_reset)
        |=> adv_reg == $past(wdata_i[`BIT_ADV_100]))
        else $error("Advertise write lost");
    a_soft_reset_spaces: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        soft_reset |=> tx_seen_reg == $past(tx_lpi_now_i)
                       && rx_seen_reg == $past(rx_lpi_now_i)
                       && partner_reg == $past(partner_adv_valid_i
                                               && partner_adv_100_i)
                       && adv_reg)
        else $error("Soft reset incomplete");
    a_disable_gates: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !enable_reg |-> !eee_negotiate_100_o)
        else $error("Disabled EEE still negotiates");
    a_ro_write_ignored: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == `ADDR_EEE_PARTNER_ABIL && !partner_adv_valid_i
         && !soft_reset) |=> $stable(partner_reg))
        else $error("Read-only write took effect");
    a_partner_update: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (partner_adv_valid_i && !soft_reset)
        |=> partner_reg == $past(partner_adv_100_i))
        else $error("Partner bit not updated");


    // Reads: reserved bits, idle data and the count hand-over; then vendor enable, strap load and advertise hold
    a_status_reserved: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (rd_i && addr_i == `ADDR_PCS_LPI_STATUS)
        |=> (rdata_o & 16'hF0BF) == 16'h0000)
        else $error("Status reserved bits set");
    a_reserved_zero: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (rd_i && (addr_i == `ADDR_EEE_LOCAL_ADV
                  || addr_i == `ADDR_EEE_PARTNER_ABIL))
        |=> rdata_o[15:2] == 14'h0000 && !rdata_o[0])
        else $error("Reserved bits set");
    a_rdata_idle: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !rd_i |=> rdata_o == 16'h0000)
        else $error("Read data outside read");
    a_count_read: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        wake_read |=> rdata_o == $past(wake_count))
        else $error("Counter read value wrong");
    a_vendor_kept: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        soft_reset |=> enable_reg == $past(enable_reg))
        else $error("Soft reset touched vendor enable");
    a_strap_load: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (strap_take && !wr_i) |=> adv_reg == $past(strap_sync_reg))
        else $error("Strap not loaded");
    a_enable_write: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (wr_i && addr_i == `ADDR_EEE_VENDOR_CFG)
        |=> enable_reg == $past(wdata_i[`BIT_EEE_ENABLE]))
        else $error("Vendor enable write lost");
    a_adv_kept: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (!wr_i && !strap_take) |=> $stable(adv_reg))
        else $error("Advertise bit changed alone");

    c_wake_read: cover property (@(posedge sys_clk_i) wake_read);
    c_soft_reset: cover property (@(posedge sys_clk_i) soft_reset);
    c_negotiate: cover property (@(posedge sys_clk_i) eee_negotiate_100_o);
    c_counter_full: cover property (
        @(posedge sys_clk_i) wake_count == `WAKE_COUNT_FULL);
    c_strap_low: cover property (
        @(posedge sys_clk_i) strap_take && !strap_sync_reg);
endmodule // eee_pcs_status_regs
`default_nettype wire

// >>> core/eee_regs_defines.svh
// Offsets, field positions and reset values of the EEE status registers.
// Assumes inclusion by the register bank and the wake-fault counter only.
`ifndef EEE_REGS_DEFINES_SVH
`define EEE_REGS_DEFINES_SVH

`define ADDR_PCS_CONTROL        16'h3000
`define ADDR_PCS_LPI_STATUS     16'h3001
`define ADDR_EEE_SPEED_CAP      16'h3014
`define ADDR_WAKE_FAULT_CNT     16'h3016
`define ADDR_EEE_LOCAL_ADV      16'h703C
`define ADDR_EEE_PARTNER_ABIL   16'h703D
`define ADDR_EEE_VENDOR_CFG     16'h04D1

`define BIT_PCS_RESET           15
`define BIT_TX_LPI_SEEN         11
`define BIT_RX_LPI_SEEN         10
`define BIT_TX_LPI_NOW          9
`define BIT_RX_LPI_NOW          8
`define BIT_TX_CLK_STOPPABLE    6
`define BIT_CAP_1000            2
`define BIT_CAP_100             1
`define BIT_ADV_100             1
`define BIT_PARTNER_100         1
`define BIT_EEE_ENABLE          0

`define RST_TX_CLK_STOPPABLE    1'b1
`define RST_CAP_100             1'b1
`define RST_CAP_1000            1'b0
`define RST_ADV_100             1'b1
`define RST_EEE_ENABLE          1'b1
`define RST_WAKE_COUNT          16'h0000
`define WAKE_COUNT_FULL         16'hFFFF

`endif

// >>> core/eee_regs_pkg.sv
// Types shared by the EEE status register bank.
// Assumes the defines header sits beside it.
`default_nettype none
package eee_regs_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    typedef struct packed {
        logic tx_lpi_now;
        logic rx_lpi_now;
        logic wake_fault;
        logic partner_adv_valid;
        logic partner_adv_100;
    } pcs_events_type;
endpackage
`default_nettype wire

// >>> core/wake_fault_counter_unit.sv
// Saturating wake-fault counter, cleared by read and by PCS soft reset.
// Assumes fault, read and clear strobes on sys_clk_i.
`default_nettype none
`include "eee_regs_defines.svh"
module wake_fault_counter_unit (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        fault_i,
    input  wire logic        read_clear_i,
    input  wire logic        soft_reset_i,
    output logic      [15:0] count_o
);
    logic [15:0] count_reg;
    logic [15:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (soft_reset_i) begin
            // A fault in the reset cycle still counts, so none is lost
            count_next = fault_i ? 16'h0001 : `RST_WAKE_COUNT;
        end else if (read_clear_i) begin
            // A fault in the read cycle still counts, so none is lost
            count_next = fault_i ? 16'h0001 : `RST_WAKE_COUNT;
        end else if (fault_i && count_reg != `WAKE_COUNT_FULL) begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= `RST_WAKE_COUNT;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count_o = count_reg;

    a_count_saturates: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (count_reg == `WAKE_COUNT_FULL && fault_i && !read_clear_i
         && !soft_reset_i) |=> count_reg == `WAKE_COUNT_FULL)
        else $error("Wake counter wrapped");
    a_count_increments: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (fault_i && !read_clear_i && !soft_reset_i
         && count_reg != `WAKE_COUNT_FULL)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("Wake counter missed a fault");
    a_soft_clears: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        soft_reset_i |=> count_reg == {15'h0000, $past(fault_i)})
        else $error("Soft reset left count");
endmodule // wake_fault_counter_unit
`default_nettype wire

// >>> verif/pcs_event_model.sv
// Far-side model: the PCS and link logic that feed the EEE status bank.
// Assumes it shares sys_clk_i with the bank and is driven by bench tasks.
`default_nettype none
module pcs_event_model
    import eee_regs_pkg::*;
(
    input  wire logic     sys_clk_i,
    output var pcs_events_type ev_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ev_o = '0;
    end

    // Live LPI levels held until changed
    task automatic set_lpi(input logic tx, input logic rx);
        @(posedge sys_clk_i);
        ev_o.tx_lpi_now <= tx;
        ev_o.rx_lpi_now <= rx;
    endtask

    // One fault per cycle held high
    task automatic wake_faults(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i);
            ev_o.wake_fault <= 1'b1;
        end
        @(posedge sys_clk_i);
        ev_o.wake_fault <= 1'b0;
    endtask

    // Ability bit is not held past its strobe, so it flips after release
    task automatic load_partner(input logic v);
        @(posedge sys_clk_i);
        ev_o.partner_adv_valid <= 1'b1;
        ev_o.partner_adv_100   <= v;
        @(posedge sys_clk_i);
        ev_o.partner_adv_valid <= 1'b0;
        ev_o.partner_adv_100   <= ~v;
    endtask
endmodule // pcs_event_model
`default_nettype wire

// >>> verif/eee_pcs_status_regs_bench.sv
// Self-checking bench for the EEE status register bank.
// Assumes the bank, its package and the event model are compiled first.
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    $display("wrong value at %0t got %h expected %h", $time, got, exp); \
    err_total++; end end
module eee_pcs_status_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import eee_regs_pkg::*;

    logic           sys_clk_i = 1'b0;
    logic           resetn_i  = 1'b0;
    logic [15:0]    addr_i    = 16'h0000;
    logic [15:0]    wdata_i   = 16'h0000;
    logic           wr_i      = 1'b0;
    logic           rd_i      = 1'b0;
    logic           adv_strap_i = 1'b1;
    logic [15:0]    rdata_o;
    logic           eee_negotiate_100_o;
    pcs_events_type ev;
    int             err_total = 0;
    int             n_tests   = 0;
    logic [15:0]    v;

    always #12.5 sys_clk_i = ~sys_clk_i;

    pcs_event_model i_pcs_event_model (.sys_clk_i(sys_clk_i), .ev_o(ev));

    eee_pcs_status_regs i_eee_pcs_status_regs (
        .sys_clk_i           (sys_clk_i),
        .resetn_i            (resetn_i),
        .addr_i              (addr_i),
        .wdata_i             (wdata_i),
        .wr_i                (wr_i),
        .rd_i                (rd_i),
        .rdata_o             (rdata_o),
        .tx_lpi_now_i        (ev.tx_lpi_now),
        .rx_lpi_now_i        (ev.rx_lpi_now),
        .wake_fault_i        (ev.wake_fault),
        .partner_adv_valid_i (ev.partner_adv_valid),
        .partner_adv_100_i   (ev.partner_adv_100),
        .adv_strap_i         (adv_strap_i),
        .eee_negotiate_100_o (eee_negotiate_100_o)
    );

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic t_reset_values;
        rd(16'h3001, v); `CHK(v, 16'h0040)
        rd(16'h3014, v); `CHK(v, 16'h0002)
        rd(16'h3016, v); `CHK(v, 16'h0000)
        rd(16'h703C, v); `CHK(v, 16'h0002)
        rd(16'h703D, v); `CHK(v, 16'h0000)
        rd(16'h1234, v); `CHK(v, 16'h0000)
        $display("reset values done");
    endtask

    task automatic t_lpi;
        i_pcs_event_model.set_lpi(1'b1, 1'b0);
        rd(16'h3001, v); `CHK(v, 16'h0A40)
        i_pcs_event_model.set_lpi(1'b0, 1'b1);
        rd(16'h3001, v); `CHK(v, 16'h0D40)
        i_pcs_event_model.set_lpi(1'b0, 1'b0);
        rd(16'h3001, v); `CHK(v, 16'h0C40)
        $display("lpi status done");
    endtask

    task automatic t_counter;
        i_pcs_event_model.wake_faults(3);
        rd(16'h3016, v); `CHK(v, 16'h0003)
        rd(16'h3016, v); `CHK(v, 16'h0000)
        // One past the top must not wrap
        i_pcs_event_model.wake_faults(65536);
        rd(16'h3016, v); `CHK(v, 16'hFFFF)
        rd(16'h3016, v); `CHK(v, 16'h0000)
        // A fault in the read cycle lands in the fresh count
        fork
            i_pcs_event_model.wake_faults(1);
            rd(16'h3016, v);
        join
        `CHK(v, 16'h0000)
        rd(16'h3016, v); `CHK(v, 16'h0001)
        $display("wake counter done");
    endtask

    task automatic t_writes;
        wr(16'h703C, 16'h0000);
        rd(16'h703C, v); `CHK(v, 16'h0000)
        wr(16'h703C, 16'hFFFF);
        rd(16'h703C, v); `CHK(v, 16'h0002)
        @(posedge sys_clk_i);
        #1 `CHK(rdata_o, 16'h0000)
        wr(16'h3014, 16'hFFFF);
        rd(16'h3014, v); `CHK(v, 16'h0002)
        wr(16'h3001, 16'h0000);
        rd(16'h3001, v); `CHK(v, 16'h0C40)
        $display("write access done");
    endtask

    task automatic t_partner;
        i_pcs_event_model.load_partner(1'b1);
        rd(16'h703D, v); `CHK(v, 16'h0002)
        `CHK(eee_negotiate_100_o, 1'b1)
        wr(16'h04D1, 16'h0000);
        @(posedge sys_clk_i);
        #1 `CHK(eee_negotiate_100_o, 1'b0)
        wr(16'h04D1, 16'h0001);
        $display("partner ability done");
    endtask

    task automatic t_soft_reset;
        i_pcs_event_model.wake_faults(2);
        wr(16'h703C, 16'h0000);
        wr(16'h3000, 16'h8000);
        rd(16'h3016, v); `CHK(v, 16'h0000)
        rd(16'h3001, v); `CHK(v, 16'h0040)
        rd(16'h703D, v); `CHK(v, 16'h0000)
        rd(16'h703C, v); `CHK(v, 16'h0002)
        `CHK(eee_negotiate_100_o, 1'b0)
        // Vendor enable survives the soft reset
        i_pcs_event_model.load_partner(1'b1);
        @(posedge sys_clk_i);
        #1 `CHK(eee_negotiate_100_o, 1'b1)
        $display("soft reset done");
    endtask

    // Strap low across a mid-run reset clears the advertise bit
    task automatic t_strap;
        @(posedge sys_clk_i);
        adv_strap_i <= 1'b0;
        resetn_i    <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        resetn_i    <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rd(16'h703C, v); `CHK(v, 16'h0000)
        rd(16'h703D, v); `CHK(v, 16'h0000)
        rd(16'h3001, v); `CHK(v, 16'h0040)
        adv_strap_i <= 1'b1;
        $display("strap and reset done");
    endtask

    initial begin
        repeat (10) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        t_reset_values();
        t_lpi();
        t_counter();
        t_writes();
        t_partner();
        t_soft_reset();
        t_strap();
        stop_test();
    end

    // Bound on the whole run
    initial begin
        #2_000_000;
        err_total++;
        stop_test();
    end
endmodule // eee_pcs_status_regs_bench
`default_nettype wire
